// ---- sim/bcb_asserts.sv ----
/*
   bcb_asserts: concurrent checks on the channel B carrier and match outputs.
   Assumes it is instantiated beside the bcb_if instance, one mclk domain.
*/
`timescale 1ns/10ps
module bcb_asserts
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // register access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [bcb_pkg::IDX_W-1:0] reg_idx,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   // observed cycle and results
   input wire logic cyc_valid,
   input wire logic cyc_ibus,
   input wire logic chb_match,
   input wire logic break_irq_req,
   input wire logic chb_local_match_flag,
   input wire logic chb_internal_match_flag
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // flag writes seen one edge late, so a clear explains a falling flag
   logic fw_q;
   logic [1:0] fwd_q;
   logic rstb_q;
   wire flag_wr = reg_wr && (reg_idx == bcb_pkg::IDX_FLAGS);
   always_ff @(posedge mclk)
   begin
      fw_q <= flag_wr;
      fwd_q <= reg_wdata[1:0];
      rstb_q <= rst_b;
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_RD_ANSWER: assert property (reg_rd && !reg_wr |=> reg_rvalid)
      else $error("read not answered next cycle");
   AST_RVALID_CAUSE: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("read answer without request");
   AST_RDATA_IDLE: assert property (!reg_rvalid |-> reg_rdata == 32'h0)
      else $error("read data not zero while idle");
   AST_BCYC_RSVD: assert property (reg_rvalid && $past(reg_idx) == bcb_pkg::IDX_BUS_CYCLE
      |-> reg_rdata[31:8] == 24'h0) else $error("bus cycle upper bits not zero");
   AST_MATCH_CAUSE: assert property (chb_match |-> $past(cyc_valid))
      else $error("match without bus cycle");
   AST_IRQ_MATCH: assert property (1'b1 |-> break_irq_req == chb_match)
      else $error("break request differs from match");
   AST_LFLAG_SET: assert property (chb_match && !$past(cyc_ibus) && !fw_q
      |-> chb_local_match_flag) else $error("local flag not set by match");
   AST_IFLAG_SET: assert property (chb_match && $past(cyc_ibus) && !fw_q
      |-> chb_internal_match_flag) else $error("internal flag not set by match");
   AST_LFLAG_HOLD: assert property ($fell(chb_local_match_flag)
      |-> (fw_q && !fwd_q[1]) || !rstb_q) else $error("local flag cleared itself");
   AST_IFLAG_HOLD: assert property ($fell(chb_internal_match_flag)
      |-> (fw_q && !fwd_q[0]) || !rstb_q) else $error("internal flag cleared itself");
   AST_FLAG_RISE: assert property ($rose(chb_local_match_flag)
      || $rose(chb_internal_match_flag) |-> chb_match) else $error("flag set without match");
endmodule

// ---- sim/break_channel_b_match_tb.sv ----
/*
   break_channel_b_match_tb: both ends joined by bcb_if, driven from the core
   user side and compared with a register and match model kept in the bench.
   Assumes the core latencies given with the design; inputs change at negedge.
*/
`timescale 1ns/10ps
module break_channel_b_match_tb;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic cmd_wr = 1'b0;
   logic cmd_rd = 1'b0;
   logic [2:0] cmd_idx = 3'h0;
   logic [31:0] cmd_wdata = 32'h0;
   logic want_data = 1'b0;
   logic rsp_valid;
   logic [31:0] rsp_data;
   logic obs_valid = 1'b0;
   logic [4:0] obs_at = 5'h0;
   logic [31:0] obs_addr = 32'h0;
   logic [31:0] obs_data = 32'h0;
   logic chb_match, break_irq_req, lflag, iflag;
   logic [31:0] m_reg [0:7] = '{default: 32'h0};
   logic [15:0] lfsr_q = 16'h0041;
   int mismatches = 0;
   int checks_done = 0;

   always #50 mclk = ~mclk;

   bcb_if bif();
   bcb_match u_bcb_match (.mclk(mclk), .rst_b(rst_b), .bus(bif), .chb_match(chb_match),
      .break_irq_req(break_irq_req), .chb_local_match_flag(lflag),
      .chb_internal_match_flag(iflag));
   bcb_core u_bcb_core (.mclk(mclk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_idx(cmd_idx), .cmd_wdata(cmd_wdata), .want_data(want_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .obs_valid(obs_valid),
      .obs_ibus(obs_at[4]), .obs_fetch(obs_at[3]), .obs_write(obs_at[2]),
      .obs_size(obs_at[1:0]), .obs_addr(obs_addr), .obs_data(obs_data), .bus(bif));
   bcb_asserts u_bcb_asserts (.mclk(mclk), .rst_b(rst_b), .reg_wr(bif.reg_wr),
      .reg_rd(bif.reg_rd), .reg_idx(bif.reg_idx), .reg_wdata(bif.reg_wdata),
      .reg_rdata(bif.reg_rdata), .reg_rvalid(bif.reg_rvalid), .cyc_valid(bif.cyc_valid),
      .cyc_ibus(bif.cyc_ibus), .chb_match(chb_match), .break_irq_req(break_irq_req),
      .chb_local_match_flag(lflag), .chb_internal_match_flag(iflag));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic results;
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic rnd(output logic [31:0] v);
      lfsr_q = lfsr_next(lfsr_q);
      v[31:16] = lfsr_q;
      lfsr_q = lfsr_next(lfsr_q);
      v[15:0] = lfsr_q;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // model follows the core: size off forced to longword when data is wanted,
   // byte size mirrors the low byte into 15:8, flag writes only clear
   task automatic wr(input logic [2:0] idx, input logic [31:0] d);
      @(negedge mclk);
      cmd_wr = 1'b1;
      cmd_idx = idx;
      cmd_wdata = d;
      @(negedge mclk);
      cmd_wr = 1'b0;
      repeat (2) @(negedge mclk);
      if (idx == bcb_pkg::IDX_BUS_CYCLE)
         d = d & 32'h0000_00ff;
      if (idx == bcb_pkg::IDX_BUS_CYCLE && want_data && d[1:0] == 2'h0)
         d[1:0] = 2'h3;
      if ((idx == bcb_pkg::IDX_DATA || idx == bcb_pkg::IDX_DATA_MASK) && m_reg[4][1:0] == 2'h1)
         d[15:8] = d[7:0];
      if (idx == bcb_pkg::IDX_FLAGS)
         d = m_reg[5] & d & 32'h3;
      if (idx < 3'h6)
         m_reg[idx] = d;
   endtask

   task automatic rd(input logic [2:0] idx);
      int n;
      @(negedge mclk);
      cmd_rd = 1'b1;
      cmd_idx = idx;
      @(negedge mclk);
      cmd_rd = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 8)
      begin
         @(negedge mclk);
         n++;
      end
      if (n == 8)
      begin
         mismatches++;
         $display("Error at %0t: read answer missing", $time);
         results();
      end
      chk(rsp_data, m_reg[idx], "read data");
   endtask

   task automatic cyc(input logic [31:0] a, input logic [31:0] dt, input logic [4:0] at);
      logic [7:0] b;
      logic hit;
      b = m_reg[4][7:0];
      hit = (b[7:6] != 2'h0) && (at[4] == (b[7:6] == 2'h2))
         && (b[5:4] == 2'h0 || b[5:4] == 2'h3 || b[4] == at[3])
         && (b[3:2] == 2'h0 || b[3:2] == 2'h3 || b[3] == at[2])
         && (b[1:0] == 2'h0 || (b[1:0] == at[1:0] && ((dt ^ m_reg[2]) & ~m_reg[3]) == 0))
         && (((a ^ m_reg[0]) & ~m_reg[1]) == 32'h0);
      @(negedge mclk);
      obs_valid = 1'b1;
      obs_addr = a;
      obs_data = dt;
      obs_at = at;
      @(negedge mclk);
      obs_valid = 1'b0;
      @(negedge mclk);
      if (hit)
         m_reg[5] = m_reg[5] | (at[4] ? 32'h1 : 32'h2);
      chk({31'h0, chb_match}, {31'h0, hit}, "match");
      chk({31'h0, break_irq_req}, {31'h0, hit}, "break request");
      chk({30'h0, lflag, iflag}, m_reg[5], "flags");
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] r, a, d;
      repeat (8) @(negedge mclk);
      rst_b = 1'b1;
      for (int i = 0; i < 8; i++)
         rd(i[2:0]);
      for (int i = 0; i < 7; i++)
      begin
         rnd(r);
         wr(i[2:0], r);
         rd(i[2:0]);
      end
      // every bus cycle setting, with addresses and data near the programmed ones
      for (int i = 0; i < 256; i++)
      begin
         rnd(r);
         want_data = r[8];
         if (i % 8 == 0)
         begin
            rnd(a);
            wr(bcb_pkg::IDX_ADDR, a);
            rnd(a);
            wr(bcb_pkg::IDX_ADDR_MASK, a & r);
            rnd(d);
            wr(bcb_pkg::IDX_DATA, {d[31:16], d[7:0], d[7:0]});
            rnd(d);
            wr(bcb_pkg::IDX_DATA_MASK, {d[31:16] & r[15:0], d[7:0], d[7:0]});
         end
         wr(bcb_pkg::IDX_BUS_CYCLE, {r[31:8], i[7:0]});
         for (int k = 0; k < 4; k++)
         begin
            rnd(r);
            rnd(a);
            rnd(d);
            cyc(r[0] ? m_reg[0] ^ (a & m_reg[1]) : a, r[1] ? m_reg[2] ^ (d & m_reg[3]) : d,
               r[8:4]);
         end
         if (i % 16 == 15)
         begin
            rd(bcb_pkg::IDX_FLAGS);
            wr(bcb_pkg::IDX_FLAGS, {30'h0, r[10:9]});
            rd(bcb_pkg::IDX_FLAGS);
         end
      end
      // second reset in mid-run clears registers and flags
      @(negedge mclk);
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      m_reg = '{default: 32'h0};
      for (int i = 0; i < 6; i++)
         rd(i[2:0]);
      results();
   end
endmodule

// ---- src/bcb_core.sv ----
/*
   bcb_core: core-side end; issues register accesses as software would and
   presents bus cycles to the match logic, one mclk late.
   Assumes user-side requests are on mclk and already well formed otherwise.
*/
`timescale 1ns/10ps
module bcb_core
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // register requests
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [bcb_pkg::IDX_W-1:0] cmd_idx,
   input wire logic [31:0] cmd_wdata,
   input wire logic want_data,
   output logic rsp_valid,
   output logic [31:0] rsp_data,
   // bus cycles to watch
   input wire logic obs_valid,
   input wire logic obs_ibus,
   input wire logic obs_fetch,
   input wire logic obs_write,
   input wire logic [1:0] obs_size,
   input wire logic [31:0] obs_addr,
   input wire logic [31:0] obs_data,
   // match logic
   bcb_if.core bus
);

   // ----------------------------------------------------------------
   // write value shaping
   // ----------------------------------------------------------------
   logic byte_mode_q;
   logic byte_mode_d;
   logic [31:0] wdata_d;
   wire is_bcyc = cmd_idx == bcb_pkg::IDX_BUS_CYCLE;
   wire is_dat = (cmd_idx == bcb_pkg::IDX_DATA) || (cmd_idx == bcb_pkg::IDX_DATA_MASK);
   wire [1:0] req_size = cmd_wdata[bcb_pkg::SIZE_LSB +: 2];
   // data compare without a size would be silently dropped; use longword
   wire [1:0] fix_size = (want_data && req_size == bcb_pkg::FLD_OFF)
                         ? bcb_pkg::SIZE_LONG : req_size;
   wire [31:0] bcyc_val = {24'h00_0000, cmd_wdata[7:2], fix_size};
   wire [31:0] dat_val = byte_mode_q
                         ? {cmd_wdata[31:16], cmd_wdata[7:0], cmd_wdata[7:0]}
                         : cmd_wdata;

   assign wdata_d = is_bcyc ? bcyc_val : (is_dat ? dat_val : cmd_wdata);
   assign byte_mode_d = (cmd_wr && is_bcyc) ? (fix_size == bcb_pkg::SIZE_BYTE) : byte_mode_q;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         byte_mode_q <= 1'b0;
         bus.reg_wr <= 1'b0;
         bus.reg_rd <= 1'b0;
         bus.reg_idx <= 3'h0;
         bus.reg_wdata <= 32'h0000_0000;
         rsp_valid <= 1'b0;
         rsp_data <= 32'h0000_0000;
      end
      else
      begin
         byte_mode_q <= byte_mode_d;
         bus.reg_wr <= cmd_wr;
         bus.reg_rd <= cmd_rd && !cmd_wr;
         bus.reg_idx <= cmd_idx;
         bus.reg_wdata <= wdata_d;
         rsp_valid <= bus.reg_rvalid;
         rsp_data <= bus.reg_rdata;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         bus.cyc_valid <= 1'b0;
         bus.cyc_ibus <= 1'b0;
         bus.cyc_fetch <= 1'b0;
         bus.cyc_write <= 1'b0;
         bus.cyc_size <= 2'h0;
         bus.cyc_addr <= 32'h0000_0000;
         bus.cyc_data <= 32'h0000_0000;
      end
      else
      begin
         bus.cyc_valid <= obs_valid;
         bus.cyc_ibus <= obs_ibus;
         bus.cyc_fetch <= obs_fetch;
         bus.cyc_write <= obs_write;
         bus.cyc_size <= obs_size;
         bus.cyc_addr <= obs_addr;
         bus.cyc_data <= obs_data;
      end
   end

endmodule

// ---- src/bcb_if.sv ----
/*
   bcb_if: carrier between the channel B match logic and the core side.
   Holds the register access group and the observed bus cycle group.
   Assumes both ends run on the same mclk; no clocking block.
*/
`timescale 1ns/10ps
interface bcb_if;

   // ----------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------
   logic reg_wr;
   logic reg_rd;
   logic [bcb_pkg::IDX_W-1:0] reg_idx;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic reg_rvalid;

   // ----------------------------------------------------------------
   // observed bus cycle
   // ----------------------------------------------------------------
   logic cyc_valid;
   logic cyc_ibus;
   logic cyc_fetch;
   logic cyc_write;
   logic [1:0] cyc_size;
   logic [bcb_pkg::ADDR_W-1:0] cyc_addr;
   logic [bcb_pkg::DATA_W-1:0] cyc_data;

   modport dev
   (
      input reg_wr, reg_rd, reg_idx, reg_wdata,
      output reg_rdata, reg_rvalid,
      input cyc_valid, cyc_ibus, cyc_fetch, cyc_write, cyc_size, cyc_addr, cyc_data
   );

   modport core
   (
      output reg_wr, reg_rd, reg_idx, reg_wdata,
      input reg_rdata, reg_rvalid,
      output cyc_valid, cyc_ibus, cyc_fetch, cyc_write, cyc_size, cyc_addr, cyc_data
   );

endinterface

// ---- src/bcb_match.sv ----
/*
   bcb_match: channel B condition match of the user break unit, with its
   register file and sticky match flags.
   Assumes the core side presents each bus cycle for one mclk with cyc_valid
   and keeps the software obligations on register contents.
*/
// Operation
// - hold 32-bit break address, compare selected bus
// - address mask bit one excludes that bit
// - hold 32-bit break data, compare data bus
// - data mask bit one excludes that bit
// - software sets size to compare data
// - byte size: same data byte both halves
// - byte size: same mask byte both halves
// - bus select: off, local, internal, local
// - cycle type: off, fetch, access, either
// - direction: off, read, write, either
// - size: ignore, byte, word, longword
// - bus cycle bits 15:8 read zero
// - match raises break interrupt request
// - sticky match flag, cleared by writing zero
`timescale 1ns/10ps
module bcb_match
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // core side
   bcb_if.dev bus,
   // toward flags and exception handling
   output logic chb_match,
   output logic break_irq_req,
   output logic chb_local_match_flag,
   output logic chb_internal_match_flag
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [31:0] break_addr_b_q;
   logic [31:0] break_addr_b_d;
   logic [31:0] break_addr_mask_b_q;
   logic [31:0] break_addr_mask_b_d;
   logic [31:0] break_data_b_q;
   logic [31:0] break_data_b_d;
   logic [31:0] break_data_mask_b_q;
   logic [31:0] break_data_mask_b_d;
   logic [7:0] break_bus_cycle_b_q;
   logic [7:0] break_bus_cycle_b_d;
   logic flag_local_q;
   logic flag_local_d;
   logic flag_internal_q;
   logic flag_internal_d;
   logic match_q;
   logic irq_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic rvalid_q;

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   wire wr_addr = bus.reg_wr && (bus.reg_idx == bcb_pkg::IDX_ADDR);
   wire wr_addr_mask = bus.reg_wr && (bus.reg_idx == bcb_pkg::IDX_ADDR_MASK);
   wire wr_data = bus.reg_wr && (bus.reg_idx == bcb_pkg::IDX_DATA);
   wire wr_data_mask = bus.reg_wr && (bus.reg_idx == bcb_pkg::IDX_DATA_MASK);
   wire wr_bus_cycle = bus.reg_wr && (bus.reg_idx == bcb_pkg::IDX_BUS_CYCLE);
   wire wr_flags = bus.reg_wr && (bus.reg_idx == bcb_pkg::IDX_FLAGS);

   assign break_addr_b_d = wr_addr ? bus.reg_wdata : break_addr_b_q;
   assign break_addr_mask_b_d = wr_addr_mask ? bus.reg_wdata : break_addr_mask_b_q;
   assign break_data_b_d = wr_data ? bus.reg_wdata : break_data_b_q;
   assign break_data_mask_b_d = wr_data_mask ? bus.reg_wdata : break_data_mask_b_q;
   // upper byte is not stored at all, so a stray write there cannot stick
   assign break_bus_cycle_b_d = wr_bus_cycle ? bus.reg_wdata[7:0] : break_bus_cycle_b_q;

   // ----------------------------------------------------------------
   // field split
   // ----------------------------------------------------------------
   wire [1:0] bsel = break_bus_cycle_b_q[bcb_pkg::BSEL_LSB +: 2];
   wire [1:0] ctype = break_bus_cycle_b_q[bcb_pkg::CTYPE_LSB +: 2];
   wire [1:0] dir = break_bus_cycle_b_q[bcb_pkg::DIR_LSB +: 2];
   wire [1:0] size = break_bus_cycle_b_q[bcb_pkg::SIZE_LSB +: 2];

   // ----------------------------------------------------------------
   // comparisons
   // ----------------------------------------------------------------
   // code 11 of the bus select means the local bus, same as 01
   wire want_local = (bsel == bcb_pkg::BSEL_LOCAL) || (bsel == bcb_pkg::BSEL_LOCAL_ALT);
   wire want_internal = (bsel == bcb_pkg::BSEL_INTERNAL);
   // bus select off leaves no bus to watch, so the channel stays quiet
   wire sel_ok = (want_local && !bus.cyc_ibus) || (want_internal && bus.cyc_ibus);

   wire type_ok = (ctype == bcb_pkg::FLD_OFF)
                  || (ctype[0] && bus.cyc_fetch)
                  || (ctype[1] && !bus.cyc_fetch);

   wire dir_ok = (dir == bcb_pkg::FLD_OFF)
                 || (dir[0] && !bus.cyc_write)
                 || (dir[1] && bus.cyc_write);

   wire size_ok = (size == bcb_pkg::FLD_OFF) || (size == bus.cyc_size);

   wire addr_ok = bcb_pkg::masked_eq(bus.cyc_addr, break_addr_b_q,
                                     break_addr_mask_b_q);

   // the data bus only takes part once a size is chosen
   wire data_ok = (size == bcb_pkg::FLD_OFF)
                  || bcb_pkg::masked_eq(bus.cyc_data, break_data_b_q,
                                        break_data_mask_b_q);

   wire hit = bus.cyc_valid && sel_ok && addr_ok && data_ok
              && type_ok && dir_ok && size_ok;

   wire set_local = hit && !bus.cyc_ibus;
   wire set_internal = hit && bus.cyc_ibus;

   // ----------------------------------------------------------------
   // sticky flags
   // ----------------------------------------------------------------
   // a match in the clearing cycle wins over the clear
   assign flag_local_d = set_local
                         || (flag_local_q
                             && !(wr_flags && !bus.reg_wdata[bcb_pkg::FLAG_LOCAL_BIT]));
   assign flag_internal_d = set_internal
                            || (flag_internal_q
                                && !(wr_flags
                                     && !bus.reg_wdata[bcb_pkg::FLAG_INTERNAL_BIT]));

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   wire [31:0] rd_bus_cycle = {16'h0000, bcb_pkg::RSVD_BUS_CYCLE, break_bus_cycle_b_q};
   wire [31:0] rd_flags = {30'h0000_0000, flag_local_q, flag_internal_q};

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      case (bus.reg_idx)
         bcb_pkg::IDX_ADDR: rdata_d = break_addr_b_q;
         bcb_pkg::IDX_ADDR_MASK: rdata_d = break_addr_mask_b_q;
         bcb_pkg::IDX_DATA: rdata_d = break_data_b_q;
         bcb_pkg::IDX_DATA_MASK: rdata_d = break_data_mask_b_q;
         bcb_pkg::IDX_BUS_CYCLE: rdata_d = rd_bus_cycle;
         bcb_pkg::IDX_FLAGS: rdata_d = rd_flags;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         break_addr_b_q <= bcb_pkg::RST_ADDR;
         break_addr_mask_b_q <= bcb_pkg::RST_ADDR_MASK;
         break_data_b_q <= bcb_pkg::RST_DATA;
         break_data_mask_b_q <= bcb_pkg::RST_DATA_MASK;
         break_bus_cycle_b_q <= bcb_pkg::RST_BUS_CYCLE;
      end
      else
      begin
         break_addr_b_q <= break_addr_b_d;
         break_addr_mask_b_q <= break_addr_mask_b_d;
         break_data_b_q <= break_data_b_d;
         break_data_mask_b_q <= break_data_mask_b_d;
         break_bus_cycle_b_q <= break_bus_cycle_b_d;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         flag_local_q <= 1'b0;
         flag_internal_q <= 1'b0;
         match_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         flag_local_q <= flag_local_d;
         flag_internal_q <= flag_internal_d;
         match_q <= hit;
         irq_q <= hit;
      end
   end

   // reads are answered one cycle later; unmapped indices read zero
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rdata_q <= bus.reg_rd ? rdata_d : 32'h0000_0000;
         rvalid_q <= bus.reg_rd;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign bus.reg_rdata = rdata_q;
   assign bus.reg_rvalid = rvalid_q;
   assign chb_match = match_q;
   assign break_irq_req = irq_q;
   assign chb_local_match_flag = flag_local_q;
   assign chb_internal_match_flag = flag_internal_q;

endmodule

// ---- src/bcb_pkg.sv ----
/*
   bcb_pkg: constants, register indices, field layouts and reset values shared
   by the channel B match logic and the core-side end.
   Assumes a single 10 MHz clock domain for both ends.
*/
package bcb_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int IDX_W = 3;
   localparam int BCYC_W = 16;
   localparam int BCYC_LIVE_W = 8;

   // ----------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_ADDR = 3'h0;
   localparam logic [IDX_W-1:0] IDX_ADDR_MASK = 3'h1;
   localparam logic [IDX_W-1:0] IDX_DATA = 3'h2;
   localparam logic [IDX_W-1:0] IDX_DATA_MASK = 3'h3;
   localparam logic [IDX_W-1:0] IDX_BUS_CYCLE = 3'h4;
   localparam logic [IDX_W-1:0] IDX_FLAGS = 3'h5;

   // ----------------------------------------------------------------
   // bus cycle register fields
   // ----------------------------------------------------------------
   localparam int BSEL_LSB = 6;
   localparam int CTYPE_LSB = 4;
   localparam int DIR_LSB = 2;
   localparam int SIZE_LSB = 0;

   // ----------------------------------------------------------------
   // flag register fields
   // ----------------------------------------------------------------
   localparam int FLAG_LOCAL_BIT = 1;
   localparam int FLAG_INTERNAL_BIT = 0;

   // ----------------------------------------------------------------
   // field encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] FLD_OFF = 2'h0;
   localparam logic [1:0] BSEL_LOCAL = 2'h1;
   localparam logic [1:0] BSEL_INTERNAL = 2'h2;
   localparam logic [1:0] BSEL_LOCAL_ALT = 2'h3;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_LONG = 2'h3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] RST_ADDR_MASK = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_DATA_MASK = 32'h0000_0000;
   localparam logic [BCYC_LIVE_W-1:0] RST_BUS_CYCLE = 8'h00;
   localparam logic [BCYC_W-BCYC_LIVE_W-1:0] RSVD_BUS_CYCLE = 8'h00;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // a set mask bit removes that bit from the comparison
   function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b,
                                      input logic [31:0] mask);
      masked_eq = (((a ^ b) & ~mask) == 32'h0000_0000);
   endfunction

endpackage
